// ---- tb/stack_mem_model.sv ----
// memory answering the sequencer's address and data bus
`timescale 1ns/1ps
module stack_mem_model (
  // clock
  input wire logic i_clk_sys,
  // bus from the sequencer
  input wire logic [15:0] i_addr,
  input wire logic i_rw,
  input wire logic [7:0] i_wdata,
  // read data back
  output logic [7:0] o_rdata
);
  logic [7:0] ram [0:65535];
  logic [7:0] last_q;
  initial begin
    for (int i = 0; i < 65536; i++) begin
      ram[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h5A;
    end
    last_q = 8'h00;
  end
  // released data bus shows the inverse of the last byte read
  assign o_rdata = (i_rw === 1'b1) ? ram[i_addr] : ~last_q;
  always @(posedge i_clk_sys) begin
    if (i_rw === 1'b0) begin
      ram[i_addr] <= i_wdata;
    end else if (i_rw === 1'b1) begin
      last_q <= ram[i_addr];
    end
  end
endmodule

// ---- tb/stack_seq_asserts.sv ----
// concurrent checks on the stack sequencer top ports
`timescale 1ns/1ps
module stack_seq_asserts (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // request
  input wire logic i_start,
  input wire stack_seq_pkg::instr_t i_instr,
  input wire stack_seq_pkg::cpu_regs_t i_regs,
  input wire logic i_irq,
  // bus and status
  input wire logic [7:0] i_data,
  input wire logic [15:0] o_addr,
  input wire logic o_rw,
  input wire logic [7:0] o_data,
  input wire logic o_data_oe_n,
  input wire logic o_busy,
  input wire logic o_waiting,
  input wire logic o_done,
  input wire stack_seq_pkg::cpu_regs_t o_regs
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  logic [15:0] sp_q;
  wire take = i_start && !o_busy;
  always_ff @(posedge i_clk_sys) begin
    if (take) begin
      sp_q <= i_regs.sp;
    end
  end
  a_oe_follows_rw: assert property (
    o_data_oe_n == o_rw) else $error("data enable differs from rw");
  a_read_no_data: assert property (
    o_rw |-> o_data == 8'h00) else $error("data driven in read cycle");
  a_idle_bus: assert property (
    !o_busy |-> o_rw && o_addr == 16'hFFFF) else $error("idle bus wrong");
  a_fetch_pair: assert property (
    take |=> o_rw && o_addr == $past(i_regs.pc) ##1
    o_rw && o_addr == $past(i_regs.pc, 2) + 16'h0001)
    else $error("fetch cycles wrong");
  a_push_acc_write: assert property (
    take && i_instr == stack_seq_pkg::push_accumulator_a |=> ##2
    !o_rw && o_addr == $past(i_regs.sp, 3) && o_data == $past(i_regs.a, 3))
    else $error("accumulator push write wrong");
  a_mul_all_ones: assert property (
    take && i_instr == stack_seq_pkg::multiply |=> ##2
    (o_rw && o_addr == 16'hFFFF)[*8] ##1 o_done)
    else $error("multiply cycles wrong");
  a_swi_vector: assert property (
    take && i_instr == stack_seq_pkg::software_interrupt |=> ##10
    o_rw && o_addr == 16'hFFFA ##1 o_rw && o_addr == 16'hFFFB ##1 o_done)
    else $error("vector fetch wrong");
  a_rti_length: assert property (
    take && i_instr == stack_seq_pkg::interrupt_return |=>
    o_busy[*5] ##1 o_busy[*5] ##1 (!o_busy && o_done))
    else $error("interrupt return length wrong");
  a_wait_addr: assert property (
    o_waiting |-> o_rw && o_addr == sp_q - 16'h0007)
    else $error("wait read address wrong");
  a_done_pulse: assert property (
    o_done |=> !o_done) else $error("done longer than one cycle");
  c_wait_end: cover property (o_waiting ##1 o_done);
  c_swi_start: cover property (
    take && i_instr == stack_seq_pkg::software_interrupt);
  c_mul_start: cover property (take && i_instr == stack_seq_pkg::multiply);
endmodule

// ---- tb/tb.sv ----
// self-checking bench for the stack instruction bus sequencer
`timescale 1ns/1ps
module tb;
  logic i_clk_sys = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_start = 1'b0;
  stack_seq_pkg::instr_t i_instr = stack_seq_pkg::push_accumulator_a;
  stack_seq_pkg::cpu_regs_t i_regs = '0;
  logic i_irq = 1'b0;
  logic [7:0] i_data;
  logic [15:0] o_addr;
  logic o_rw;
  logic [7:0] o_data;
  logic o_data_oe_n;
  logic o_busy;
  logic o_waiting;
  logic o_done;
  stack_seq_pkg::cpu_regs_t o_regs;
  int fails = 0;
  int comparisons = 0;
  logic [27:0] exp_list[$];
  stack_seq_pkg::cpu_regs_t r;
  stack_seq_pkg::cpu_regs_t e;

  always #20 i_clk_sys = ~i_clk_sys;

  stack_instruction_bus_sequencer uut (.i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n), .i_start(i_start), .i_instr(i_instr),
    .i_regs(i_regs), .i_irq(i_irq), .i_data(i_data), .o_addr(o_addr),
    .o_rw(o_rw), .o_data(o_data), .o_data_oe_n(o_data_oe_n),
    .o_busy(o_busy), .o_waiting(o_waiting), .o_done(o_done),
    .o_regs(o_regs));
  stack_mem_model mem (.i_clk_sys(i_clk_sys), .i_addr(o_addr),
    .i_rw(o_rw), .i_wdata(o_data), .o_rdata(i_data));

  function automatic logic [7:0] pat(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction
  task automatic judge(input logic ok, input logic [87:0] got,
                       input logic [87:0] exp);
    comparisons++;
    if (!ok) begin
      fails++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_bus(input logic [27:0] got, input logic [27:0] exp);
    judge(got === exp, {60'h0, got}, {60'h0, exp});
  endtask
  task automatic chk_regs(input stack_seq_pkg::cpu_regs_t got,
                          input stack_seq_pkg::cpu_regs_t exp);
    judge(got === exp, got, exp);
  endtask
  task automatic end_sim();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic rd(input logic [15:0] a, input logic w = 1'b0);
    exp_list.push_back({a, 1'b1, 8'h00, 1'b1, 1'b1, w});
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    exp_list.push_back({a, 1'b0, d, 1'b0, 1'b1, 1'b0});
  endtask
  task automatic fetch();
    rd(r.pc);
    rd(r.pc + 16'h0001);
  endtask
  task automatic stack7();
    logic [15:0] ra;
    logic [7:0] v [7];
    ra = r.pc + 16'h0001;
    v = '{ra[7:0], ra[15:8], r.x[7:0], r.x[15:8], r.a, r.b, r.ccr};
    for (int i = 0; i < 7; i++) wr(r.sp - 16'(i), v[i]);
  endtask
  // starts at a falling edge, checks every bus cycle, then done and results
  task automatic run(input stack_seq_pkg::instr_t ins, input int irq_at);
    int n;
    n = exp_list.size();
    i_instr = ins;
    i_regs = r;
    i_start = 1'b1;
    @(negedge i_clk_sys);
    i_start = 1'b0;
    for (int k = 1; k <= n; k++) begin
      chk_bus({o_addr, o_rw, o_data, o_data_oe_n, o_busy, o_waiting},
              exp_list[k - 1]);
      i_irq = (k == irq_at);
      @(negedge i_clk_sys);
    end
    i_irq = 1'b0;
    chk_bus({o_addr, o_rw, o_data, o_data_oe_n, o_busy, o_done},
            {16'hFFFF, 1'b1, 8'h00, 1'b1, 1'b0, 1'b1});
    chk_regs(o_regs, e);
    exp_list.delete();
  endtask

  task automatic t_short();
    r = '{16'h1000, 16'h20F0, 16'h3456, 8'hA1, 8'hB2, 8'h0C};
    e = r;
    e.sp = r.sp - 16'h0001;
    e.pc = r.pc + 16'h0001;
    fetch();
    wr(r.sp, r.a);
    run(stack_seq_pkg::push_accumulator_a, 0);
    r = e;
    e.sp = r.sp - 16'h0001;
    e.pc = r.pc + 16'h0001;
    fetch();
    wr(r.sp, r.b);
    run(stack_seq_pkg::push_accumulator_b, 0);
    r = e;
    e.x = r.sp;
    e.pc = r.pc + 16'h0001;
    fetch();
    rd(r.sp);
    run(stack_seq_pkg::stack_to_index_transfer, 0);
    r = e;
    r.x = 16'h5A5A;
    e = r;
    e.sp = 16'h5A5A;
    e.pc = r.pc + 16'h0001;
    fetch();
    rd(16'hFFFF);
    run(stack_seq_pkg::index_to_stack_transfer, 0);
  endtask
  task automatic t_index_round_trip();
    r = '{16'h1100, 16'h3000, 16'hC3E1, 8'h11, 8'h22, 8'h33};
    e = r;
    e.sp = r.sp - 16'h0002;
    e.pc = r.pc + 16'h0001;
    fetch();
    wr(r.sp, r.x[7:0]);
    wr(r.sp - 16'h0001, r.x[15:8]);
    run(stack_seq_pkg::push_index, 0);
    r = e;
    r.x = 16'h0000;
    e.sp = r.sp + 16'h0002;
    e.pc = r.pc + 16'h0001;
    fetch();
    for (int i = 0; i < 3; i++) rd(r.sp + 16'(i));
    run(stack_seq_pkg::pull_index, 0);
    r = '{16'h1200, 16'h4100, 16'h0, 8'h0, 8'h0, 8'h0};
    e = r;
    e.a = pat(16'h4101);
    e.pc = r.pc + 16'h0001;
    e.sp = 16'h4101;
    fetch();
    rd(r.sp);
    rd(r.sp + 16'h0001);
    run(stack_seq_pkg::pull_accumulator_a, 0);
    r = e;
    e.b = pat(16'h4102);
    e.sp = 16'h4102;
    e.pc = r.pc + 16'h0001;
    fetch();
    rd(r.sp);
    rd(r.sp + 16'h0001);
    run(stack_seq_pkg::pull_accumulator_b, 0);
  endtask
  task automatic t_rts();
    r = '{16'h1300, 16'h4200, 16'h1, 8'h2, 8'h3, 8'h4};
    e = r;
    e.sp = 16'h4202;
    e.pc = {pat(16'h4201), pat(16'h4202)};
    fetch();
    for (int i = 0; i < 3; i++) rd(r.sp + 16'(i));
    run(stack_seq_pkg::subroutine_return, 0);
  endtask
  task automatic t_wait_and_return();
    stack_seq_pkg::cpu_regs_t w;
    r = '{16'h14FF, 16'h2100, 16'h9ABC, 8'hD1, 8'hE2, 8'hF3};
    w = r;
    e = r;
    e.sp = r.sp - 16'h0007;
    e.pc = r.pc + 16'h0001;
    fetch();
    stack7();
    for (int i = 0; i < 3; i++) rd(r.sp - 16'h0007, 1'b1);
    run(stack_seq_pkg::wait_for_interrupt, 12);
    r = e;
    r.x = 16'h0;
    r.a = 8'h0;
    r.b = 8'h0;
    r.ccr = 8'h0;
    r.pc = 16'h1600;
    e = w;
    e.pc = w.pc + 16'h0001;
    fetch();
    for (int i = 0; i < 8; i++) rd(r.sp + 16'(i));
    run(stack_seq_pkg::interrupt_return, 0);
  endtask
  task automatic t_mul();
    r = '{16'h1700, 16'h2200, 16'h77, 8'hFF, 8'hFE, 8'h05};
    e = r;
    e.a = 8'hFD;
    e.b = 8'h02;
    e.pc = r.pc + 16'h0001;
    fetch();
    for (int i = 0; i < 8; i++) rd(16'hFFFF);
    run(stack_seq_pkg::multiply, 0);
  endtask
  task automatic t_swi();
    r = '{16'h1800, 16'h2300, 16'h4455, 8'h66, 8'h77, 8'h88};
    e = r;
    e.sp = r.sp - 16'h0007;
    e.pc = {pat(16'hFFFA), pat(16'hFFFB)};
    fetch();
    stack7();
    rd(r.sp - 16'h0007);
    rd(16'hFFFA);
    rd(16'hFFFB);
    run(stack_seq_pkg::software_interrupt, 0);
  endtask

  initial begin
    repeat (2) @(negedge i_clk_sys);
    i_rst_n = 1'b1;
    chk_bus({o_addr, o_rw, o_data, o_data_oe_n, o_busy, o_done},
            {16'hFFFF, 1'b1, 8'h00, 1'b1, 1'b0, 1'b0});
    chk_regs(o_regs, '0);
    t_short();
    t_index_round_trip();
    t_rts();
    t_wait_and_return();
    t_mul();
    t_swi();
    end_sim();
  end
endmodule

bind stack_instruction_bus_sequencer stack_seq_asserts chk (
  .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_start(i_start),
  .i_instr(i_instr), .i_regs(i_regs), .i_irq(i_irq), .i_data(i_data),
  .o_addr(o_addr), .o_rw(o_rw), .o_data(o_data),
  .o_data_oe_n(o_data_oe_n), .o_busy(o_busy), .o_waiting(o_waiting),
  .o_done(o_done), .o_regs(o_regs));

// ---- verilog/stack_instruction_bus_sequencer.sv ----
// bus sequencer for implied-mode stack, return, interrupt and multiply ops
// Notes on behaviour
// - accumulator push and the two transfers take 3 cycles, third by kind
// - index push: 4 cycles, low byte at pointer then high at pointer-1
// - pulls: dummy read at pointer, then bytes from pointer+1 upward
// - subroutine return: 5 cycles, return high then low from the stack
// - wait: 9 cycles then waiting reads, seven bytes stacked downward from the pointer
// - multiply: 10 cycles, cycles 3 to 10 read all-ones, data ignored
// - interrupt return restores ccr, b, a, index high and low upward
// - interrupt return then reads resume address and continues there
// - software interrupt stacks like wait, then dummy read at pointer-7
// - software interrupt fetches handler high and low from its vector
// - read/write line low only when stacking a byte, high otherwise
// - after wait stacking, repeat reads at pointer-7 until interrupt
`timescale 1ns/1ps
module stack_instruction_bus_sequencer (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // instruction request
  input wire logic i_start,
  input wire stack_seq_pkg::instr_t i_instr,
  input wire stack_seq_pkg::cpu_regs_t i_regs,
  input wire logic i_irq,
  // external bus
  input wire logic [7:0] i_data,
  output logic [15:0] o_addr,
  output logic o_rw,
  output logic [7:0] o_data,
  output logic o_data_oe_n,
  // status and results
  output logic o_busy,
  output logic o_waiting,
  output logic o_done,
  output stack_seq_pkg::cpu_regs_t o_regs
);

  // sequencing state
  logic busy_q;
  logic busy_d;
  logic [3:0] cyc_q;
  logic [3:0] cyc_d;
  stack_seq_pkg::instr_t instr_q;
  stack_seq_pkg::instr_t instr_d;
  stack_seq_pkg::bus_step_t step_q;
  stack_seq_pkg::bus_step_t step_d;
  stack_seq_pkg::bus_step_t step_table;
  stack_seq_pkg::cpu_regs_t work_q;
  stack_seq_pkg::cpu_regs_t work_d;
  stack_seq_pkg::cpu_regs_t loaded;
  stack_seq_pkg::cpu_regs_t final_regs;
  stack_seq_pkg::cpu_regs_t regs_q;

  // registered bus and status
  logic [15:0] addr_q;
  logic [15:0] addr_d;
  logic rw_q;
  logic rw_d;
  logic [7:0] data_q;
  logic [7:0] data_d;
  logic oe_n_q;
  logic oe_n_d;
  logic waiting_q;
  logic done_q;

  // control terms
  logic accept;
  logic finishing;
  logic pc_from_stack;
  logic [15:0] ret_addr;
  logic [15:0] mul_product;
  logic [15:0] pc_next;
  logic [15:0] ptr_up;

  assign accept = i_start & ~busy_q;
  // a waiting cycle ends only once an interrupt is seen
  assign finishing = busy_q & (step_q.last | (step_q.hold & i_irq));
  assign busy_d = accept | (busy_q & ~finishing);

  assign instr_d = accept ? i_instr : instr_q;
  assign cyc_d = accept ? stack_seq_pkg::CYC_OPCODE :
                 (~busy_q | step_q.hold) ? cyc_q :
                 cyc_q + stack_seq_pkg::CYC_STEP;

  stack_step_decoder u_step_decoder (
    .i_instr(instr_d),
    .i_cyc(cyc_d),
    .o_step(step_table)
  );

  // idle bus is a read of all-ones
  assign step_d = busy_d ? step_table : stack_seq_pkg::STEP_IDLE;

  assign ret_addr = work_q.pc + stack_seq_pkg::WORD_STEP;
  assign mul_product = 16'(work_q.a * work_q.b);
  assign pc_from_stack = (instr_q == stack_seq_pkg::subroutine_return) |
                         (instr_q == stack_seq_pkg::interrupt_return) |
                         (instr_q == stack_seq_pkg::software_interrupt);

  // capture read data and move the pointer for the cycle just ended
  always_comb begin
    loaded = work_q;
    unique case (step_q.dst)
      stack_seq_pkg::BYTE_ACC_A: loaded.a = i_data;
      stack_seq_pkg::BYTE_ACC_B: loaded.b = i_data;
      stack_seq_pkg::BYTE_INDEX_HI: loaded.x[15:8] = i_data;
      stack_seq_pkg::BYTE_INDEX_LO: loaded.x[7:0] = i_data;
      stack_seq_pkg::BYTE_PC_HI: loaded.pc[15:8] = i_data;
      stack_seq_pkg::BYTE_PC_LO: loaded.pc[7:0] = i_data;
      stack_seq_pkg::BYTE_CCR: loaded.ccr = i_data;
      stack_seq_pkg::BYTE_NONE,
      stack_seq_pkg::BYTE_RET_HI,
      stack_seq_pkg::BYTE_RET_LO: begin
      end
    endcase
    unique case (step_q.ptr)
      stack_seq_pkg::PTR_DEC:
        loaded.sp = work_q.sp - stack_seq_pkg::WORD_STEP;
      stack_seq_pkg::PTR_INC:
        loaded.sp = work_q.sp + stack_seq_pkg::WORD_STEP;
      stack_seq_pkg::PTR_HOLD: begin
      end
    endcase
  end

  // effects applied when the last cycle completes
  always_comb begin
    final_regs = loaded;
    if (!pc_from_stack) begin
      final_regs.pc = ret_addr;
    end
    unique case (instr_q)
      stack_seq_pkg::multiply: begin
        final_regs.a = mul_product[15:8];
        final_regs.b = mul_product[7:0];
      end
      stack_seq_pkg::stack_to_index_transfer: final_regs.x = loaded.sp;
      stack_seq_pkg::index_to_stack_transfer: final_regs.sp = loaded.x;
      stack_seq_pkg::push_accumulator_a,
      stack_seq_pkg::push_accumulator_b,
      stack_seq_pkg::pull_accumulator_a,
      stack_seq_pkg::pull_accumulator_b,
      stack_seq_pkg::push_index,
      stack_seq_pkg::pull_index,
      stack_seq_pkg::subroutine_return,
      stack_seq_pkg::wait_for_interrupt,
      stack_seq_pkg::interrupt_return,
      stack_seq_pkg::software_interrupt: begin
      end
    endcase
  end

  assign work_d = accept ? i_regs :
                  finishing ? final_regs :
                  busy_q ? loaded : work_q;

  // next bus address from the working copy
  assign pc_next = work_d.pc + stack_seq_pkg::WORD_STEP;
  assign ptr_up = work_d.sp + stack_seq_pkg::WORD_STEP;

  always_comb begin
    unique case (step_d.addr)
      stack_seq_pkg::ADDR_SEL_PC: addr_d = work_d.pc;
      stack_seq_pkg::ADDR_SEL_PC_NEXT: addr_d = pc_next;
      stack_seq_pkg::ADDR_SEL_PTR: addr_d = work_d.sp;
      stack_seq_pkg::ADDR_SEL_PTR_UP: addr_d = ptr_up;
      stack_seq_pkg::ADDR_SEL_ALL_ONES:
        addr_d = stack_seq_pkg::ADDR_ALL_ONES;
      stack_seq_pkg::ADDR_SEL_VEC_HI:
        addr_d = stack_seq_pkg::VEC_SWI_HI;
      stack_seq_pkg::ADDR_SEL_VEC_LO:
        addr_d = stack_seq_pkg::VEC_SWI_LO;
      default: addr_d = stack_seq_pkg::ADDR_ALL_ONES;
    endcase
  end

  // next write data from the working copy
  always_comb begin
    unique case (step_d.src)
      stack_seq_pkg::BYTE_ACC_A: data_d = work_d.a;
      stack_seq_pkg::BYTE_ACC_B: data_d = work_d.b;
      stack_seq_pkg::BYTE_INDEX_HI: data_d = work_d.x[15:8];
      stack_seq_pkg::BYTE_INDEX_LO: data_d = work_d.x[7:0];
      stack_seq_pkg::BYTE_RET_HI: data_d = pc_next[15:8];
      stack_seq_pkg::BYTE_RET_LO: data_d = pc_next[7:0];
      stack_seq_pkg::BYTE_CCR: data_d = work_d.ccr;
      stack_seq_pkg::BYTE_NONE,
      stack_seq_pkg::BYTE_PC_HI,
      stack_seq_pkg::BYTE_PC_LO: data_d = stack_seq_pkg::DATA_IDLE;
      default: data_d = stack_seq_pkg::DATA_IDLE;
    endcase
  end

  assign rw_d = step_d.write ? stack_seq_pkg::RW_WRITE :
                stack_seq_pkg::RW_READ;
  assign oe_n_d = ~step_d.write;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      busy_q <= 1'b0;
      cyc_q <= stack_seq_pkg::CYC_NONE;
      instr_q <= stack_seq_pkg::push_accumulator_a;
      step_q <= stack_seq_pkg::STEP_IDLE;
      work_q <= stack_seq_pkg::REGS_RESET;
    end else begin
      busy_q <= busy_d;
      cyc_q <= cyc_d;
      instr_q <= instr_d;
      step_q <= step_d;
      work_q <= work_d;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      addr_q <= stack_seq_pkg::ADDR_ALL_ONES;
      rw_q <= stack_seq_pkg::RW_READ;
      data_q <= stack_seq_pkg::DATA_IDLE;
      oe_n_q <= 1'b1;
    end else begin
      addr_q <= addr_d;
      rw_q <= rw_d;
      data_q <= data_d;
      oe_n_q <= oe_n_d;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      waiting_q <= 1'b0;
      done_q <= 1'b0;
      regs_q <= stack_seq_pkg::REGS_RESET;
    end else begin
      waiting_q <= step_d.hold;
      done_q <= finishing;
      if (finishing) begin
        regs_q <= final_regs;
      end
    end
  end

  assign o_addr = addr_q;
  assign o_rw = rw_q;
  assign o_data = data_q;
  assign o_data_oe_n = oe_n_q;
  assign o_busy = busy_q;
  assign o_waiting = waiting_q;
  assign o_done = done_q;
  assign o_regs = regs_q;

endmodule

// ---- verilog/stack_seq_pkg.sv ----
// constants and types for the stack and return instruction bus sequencer
package stack_seq_pkg;

  // fixed bus addresses
  localparam logic [15:0] ADDR_ALL_ONES = 16'hFFFF;
  localparam logic [15:0] VEC_SWI_HI = 16'hFFFA;
  localparam logic [15:0] VEC_SWI_LO = 16'hFFFB;

  // read/write line levels
  localparam logic RW_READ = 1'b1;
  localparam logic RW_WRITE = 1'b0;

  localparam logic [15:0] WORD_STEP = 16'h0001;
  localparam logic [7:0] DATA_IDLE = 8'h00;

  // bus cycle numbers, counted from one
  localparam logic [3:0] CYC_NONE = 4'h0;
  localparam logic [3:0] CYC_STEP = 4'h1;
  localparam logic [3:0] CYC_OPCODE = 4'h1;
  localparam logic [3:0] CYC_NEXT_BYTE = 4'h2;
  localparam logic [3:0] CYC_EXEC = 4'h3;
  localparam logic [3:0] CYC_PULL_FIRST = 4'h4;
  localparam logic [3:0] CYC_STACK_LAST = 4'h9;
  localparam logic [3:0] CYC_SWI_DUMMY = 4'hA;
  localparam logic [3:0] CYC_SWI_VEC_HI = 4'hB;

  // total cycles per instruction
  localparam logic [3:0] CYC_LEN_SHORT = 4'h3;
  localparam logic [3:0] CYC_LEN_PULL_A = 4'h4;
  localparam logic [3:0] CYC_LEN_PUSH_X = 4'h4;
  localparam logic [3:0] CYC_LEN_PULL_X = 4'h5;
  localparam logic [3:0] CYC_LEN_RTS = 4'h5;
  localparam logic [3:0] CYC_LEN_WAI = 4'h9;
  localparam logic [3:0] CYC_LEN_MUL = 4'hA;
  localparam logic [3:0] CYC_LEN_RTI = 4'hA;
  localparam logic [3:0] CYC_LEN_SWI = 4'hC;

  typedef enum logic [3:0] {
    push_accumulator_a,
    push_accumulator_b,
    stack_to_index_transfer,
    index_to_stack_transfer,
    pull_accumulator_a,
    pull_accumulator_b,
    push_index,
    pull_index,
    subroutine_return,
    wait_for_interrupt,
    multiply,
    interrupt_return,
    software_interrupt
  } instr_t;

  typedef enum logic [2:0] {
    ADDR_SEL_PC,
    ADDR_SEL_PC_NEXT,
    ADDR_SEL_PTR,
    ADDR_SEL_PTR_UP,
    ADDR_SEL_ALL_ONES,
    ADDR_SEL_VEC_HI,
    ADDR_SEL_VEC_LO
  } addr_sel_t;

  typedef enum logic [3:0] {
    BYTE_NONE,
    BYTE_ACC_A,
    BYTE_ACC_B,
    BYTE_INDEX_HI,
    BYTE_INDEX_LO,
    BYTE_PC_HI,
    BYTE_PC_LO,
    BYTE_RET_HI,
    BYTE_RET_LO,
    BYTE_CCR
  } byte_sel_t;

  typedef enum logic [1:0] {
    PTR_HOLD,
    PTR_DEC,
    PTR_INC
  } ptr_op_t;

  typedef struct packed {
    addr_sel_t addr;
    logic write;
    byte_sel_t src;
    byte_sel_t dst;
    ptr_op_t ptr;
    logic last;
    logic hold;
  } bus_step_t;

  typedef struct packed {
    logic [15:0] pc;
    logic [15:0] sp;
    logic [15:0] x;
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] ccr;
  } cpu_regs_t;

  localparam bus_step_t STEP_IDLE = '{ADDR_SEL_ALL_ONES, 1'b0, BYTE_NONE,
                                      BYTE_NONE, PTR_HOLD, 1'b0, 1'b0};
  localparam cpu_regs_t REGS_RESET = '0;

endpackage

// ---- verilog/stack_step_decoder.sv ----
// per-cycle bus step table for each sequenced instruction
`timescale 1ns/1ps
module stack_step_decoder (
  // instruction and cycle number
  input wire stack_seq_pkg::instr_t i_instr,
  input wire logic [3:0] i_cyc,
  // step to perform in that cycle
  output stack_seq_pkg::bus_step_t o_step
);

  logic [3:0] stack_idx;
  logic [3:0] rti_idx;
  stack_seq_pkg::byte_sel_t stack_src;
  stack_seq_pkg::byte_sel_t rti_dst;
  stack_seq_pkg::bus_step_t step;

  assign stack_idx = i_cyc - stack_seq_pkg::CYC_EXEC;
  assign rti_idx = i_cyc - stack_seq_pkg::CYC_PULL_FIRST;

  // stacking order of interrupt frames
  always_comb begin
    unique case (stack_idx)
      4'h0: stack_src = stack_seq_pkg::BYTE_RET_LO;
      4'h1: stack_src = stack_seq_pkg::BYTE_RET_HI;
      4'h2: stack_src = stack_seq_pkg::BYTE_INDEX_LO;
      4'h3: stack_src = stack_seq_pkg::BYTE_INDEX_HI;
      4'h4: stack_src = stack_seq_pkg::BYTE_ACC_A;
      4'h5: stack_src = stack_seq_pkg::BYTE_ACC_B;
      default: stack_src = stack_seq_pkg::BYTE_CCR;
    endcase
  end

  // restore order of interrupt return
  always_comb begin
    unique case (rti_idx)
      4'h0: rti_dst = stack_seq_pkg::BYTE_CCR;
      4'h1: rti_dst = stack_seq_pkg::BYTE_ACC_B;
      4'h2: rti_dst = stack_seq_pkg::BYTE_ACC_A;
      4'h3: rti_dst = stack_seq_pkg::BYTE_INDEX_HI;
      4'h4: rti_dst = stack_seq_pkg::BYTE_INDEX_LO;
      4'h5: rti_dst = stack_seq_pkg::BYTE_PC_HI;
      default: rti_dst = stack_seq_pkg::BYTE_PC_LO;
    endcase
  end

  always_comb begin
    step = stack_seq_pkg::STEP_IDLE;
    if (i_cyc == stack_seq_pkg::CYC_OPCODE) begin
      step.addr = stack_seq_pkg::ADDR_SEL_PC;
    end else if (i_cyc == stack_seq_pkg::CYC_NEXT_BYTE) begin
      step.addr = stack_seq_pkg::ADDR_SEL_PC_NEXT;
    end else begin
      unique case (i_instr)
        stack_seq_pkg::push_accumulator_a,
        stack_seq_pkg::push_accumulator_b: begin
          step.addr = stack_seq_pkg::ADDR_SEL_PTR;
          step.write = 1'b1;
          step.src = (i_instr == stack_seq_pkg::push_accumulator_a) ?
                     stack_seq_pkg::BYTE_ACC_A : stack_seq_pkg::BYTE_ACC_B;
          step.ptr = stack_seq_pkg::PTR_DEC;
          step.last = 1'b1;
        end
        stack_seq_pkg::stack_to_index_transfer: begin
          step.addr = stack_seq_pkg::ADDR_SEL_PTR;
          step.last = 1'b1;
        end
        stack_seq_pkg::index_to_stack_transfer: begin
          step.addr = stack_seq_pkg::ADDR_SEL_ALL_ONES;
          step.last = 1'b1;
        end
        stack_seq_pkg::push_index: begin
          step.addr = stack_seq_pkg::ADDR_SEL_PTR;
          step.write = 1'b1;
          step.src = (i_cyc == stack_seq_pkg::CYC_EXEC) ?
                     stack_seq_pkg::BYTE_INDEX_LO :
                     stack_seq_pkg::BYTE_INDEX_HI;
          step.ptr = stack_seq_pkg::PTR_DEC;
          step.last = (i_cyc == stack_seq_pkg::CYC_LEN_PUSH_X);
        end
        stack_seq_pkg::pull_accumulator_a,
        stack_seq_pkg::pull_accumulator_b,
        stack_seq_pkg::pull_index,
        stack_seq_pkg::subroutine_return,
        stack_seq_pkg::interrupt_return: begin
          if (i_cyc == stack_seq_pkg::CYC_EXEC) begin
            step.addr = stack_seq_pkg::ADDR_SEL_PTR;
          end else begin
            step.addr = stack_seq_pkg::ADDR_SEL_PTR_UP;
            step.ptr = stack_seq_pkg::PTR_INC;
            unique case (i_instr)
              stack_seq_pkg::pull_accumulator_a: begin
                step.dst = stack_seq_pkg::BYTE_ACC_A;
                step.last = 1'b1;
              end
              stack_seq_pkg::pull_accumulator_b: begin
                step.dst = stack_seq_pkg::BYTE_ACC_B;
                step.last = 1'b1;
              end
              stack_seq_pkg::pull_index: begin
                step.dst = (i_cyc == stack_seq_pkg::CYC_PULL_FIRST) ?
                           stack_seq_pkg::BYTE_INDEX_HI :
                           stack_seq_pkg::BYTE_INDEX_LO;
                step.last = (i_cyc == stack_seq_pkg::CYC_LEN_PULL_X);
              end
              stack_seq_pkg::subroutine_return: begin
                step.dst = (i_cyc == stack_seq_pkg::CYC_PULL_FIRST) ?
                           stack_seq_pkg::BYTE_PC_HI :
                           stack_seq_pkg::BYTE_PC_LO;
                step.last = (i_cyc == stack_seq_pkg::CYC_LEN_RTS);
              end
              default: begin
                step.dst = rti_dst;
                step.last = (i_cyc == stack_seq_pkg::CYC_LEN_RTI);
              end
            endcase
          end
        end
        stack_seq_pkg::multiply: begin
          step.addr = stack_seq_pkg::ADDR_SEL_ALL_ONES;
          step.last = (i_cyc == stack_seq_pkg::CYC_LEN_MUL);
        end
        stack_seq_pkg::wait_for_interrupt,
        stack_seq_pkg::software_interrupt: begin
          step.addr = stack_seq_pkg::ADDR_SEL_PTR;
          if (i_cyc <= stack_seq_pkg::CYC_STACK_LAST) begin
            step.write = 1'b1;
            step.src = stack_src;
            step.ptr = stack_seq_pkg::PTR_DEC;
          end else if (i_instr == stack_seq_pkg::wait_for_interrupt) begin
            step.hold = 1'b1;
          end else if (i_cyc == stack_seq_pkg::CYC_SWI_VEC_HI) begin
            step.addr = stack_seq_pkg::ADDR_SEL_VEC_HI;
            step.dst = stack_seq_pkg::BYTE_PC_HI;
          end else if (i_cyc == stack_seq_pkg::CYC_LEN_SWI) begin
            step.addr = stack_seq_pkg::ADDR_SEL_VEC_LO;
            step.dst = stack_seq_pkg::BYTE_PC_LO;
            step.last = 1'b1;
          end
        end
      endcase
    end
  end

  assign o_step = step;

endmodule
